/* logic/mps_sequencer.sv */
// Instruction sequencer: phases, counter, stack, vectors, APB
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mps_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Program memory
	output logic [mps_pkg::PC_W-1:0] prog_addr,
	output logic prog_rd,
	input wire logic [15:0] prog_data,
	// Data memory operand path
	output logic [7:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	// Interrupt requests from enable logic, lowest index first
	input wire logic [mps_pkg::IRQ_N-1:0] irq_req,
	output logic [mps_pkg::IRQ_N-1:0] irq_ack,
	output logic irq_ret,
	// Oscillator strap and spare pin
	input wire logic rc_mode_pin,
	output logic osc_out_pin
);
	import mps_pkg::*;

	// Strap synchroniser stages
	logic rc_meta;
	logic rc_mode;
	// Phase generator
	mps_phase_t ph;
	mps_phase_t next_ph;
	// Program counter and pipeline words
	logic [PC_W-1:0] pc;
	logic [15:0] ir;
	logic [15:0] fetch_buf;
	// Accumulator and status
	logic [7:0] acc;
	mps_flags_t flags;
	// Hidden return stack
	logic [PC_W-1:0] stk [STK_DEPTH];
	logic [2:0] stack_index;
	logic [3:0] stk_cnt;
	logic stk_full;
	logic [PC_W-1:0] stk_top;
	// Software run control
	logic run;
	// Decode of the executing word
	logic [1:0] cls;
	logic is_jmp;
	logic is_call;
	logic is_ret;
	logic is_interrupt_return_op;
	logic is_alu;
	logic ir_flow;
	// ALU outputs
	logic [7:0] alu_res;
	mps_flags_t alu_flags;
	logic alu_skip;
	// Execute strobes
	logic exec_go;
	logic skip_go;
	logic ack_go;
	logic flush;
	logic push;
	logic pop;
	logic [PC_W-1:0] ret_addr;
	logic [IRQ_N-1:0] irq_sel;
	logic [PC_W-1:0] irq_vec;
	// APB decode
	logic hit_pcl;
	logic hit_stat;
	logic hit_ctrl;
	logic acc_phase;
	logic pcl_wr;
	logic pcl_go;
	logic [31:0] rd_word;

	// Lowest pending request wins
	function automatic logic [IRQ_N-1:0] pick_irq(input logic [IRQ_N-1:0] r);
		pick_irq = r & (~r + IRQ_N'(1));
	endfunction

	// Vector address of a one-hot request
	function automatic logic [PC_W-1:0] vec_of(input logic [IRQ_N-1:0] oh);
		vec_of = RESET_VEC;
		for (int i = 0; i < IRQ_N; i++) begin
			if (oh[i])
				vec_of = VEC_BASE + VEC_STEP * PC_W'(i);
		end
	endfunction

	// Strap crosses in through two flops; only the second is read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_meta <= 1'b0;
			rc_mode <= 1'b0;
		end else if (clk_en) begin
			rc_meta <= rc_mode_pin;
			rc_mode <= rc_meta;
		end
	end

	// Phase rotation, one instruction cycle per lap
	always_comb begin
		case (ph)
			PH_T1: next_ph = PH_T2;
			PH_T2: next_ph = PH_T3;
			PH_T3: next_ph = PH_T4;
			PH_T4: next_ph = PH_T1;
			default: next_ph = PH_T1;
		endcase
	end

	// Phase register runs even when halted so the pin keeps ticking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ph <= PH_T1;
		else if (clk_en)
			ph <= next_ph;
	end

	// Phase one on the spare pin: high one quarter, low three
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			osc_out_pin <= 1'b0;
		else if (clk_en)
			osc_out_pin <= rc_mode && (next_ph == PH_T1);
	end

	// Word decode
	assign cls = ir[F_CLS_HI:F_CLS_LO];
	assign is_jmp = (cls == CLS_JMP) && !ir[F_CALL];
	assign is_call = (cls == CLS_JMP) && ir[F_CALL];
	assign is_ret = (cls == CLS_MISC) && (ir[F_MSUB_HI:F_MSUB_LO] == MISC_RET);
	assign is_interrupt_return_op = (cls == CLS_MISC) && (ir[F_MSUB_HI:F_MSUB_LO] == MISC_INTERRUPT_RETURN_OP);
	assign is_alu = (cls == CLS_ALU);
	assign ir_flow = is_jmp || is_call || is_ret || is_interrupt_return_op;

	// Operand path straight from the executing word
	assign mem_addr = ir[7:0];

	mps_alu u_alu (
		.op(mps_alu_op_t'(ir[F_FN_HI:F_FN_LO])),
		.a(acc),
		.b(mem_rdata),
		.flags_in(flags),
		.result(alu_res),
		.flags_out(alu_flags),
		.skip(alu_skip)
	);

	// Execution happens at the end of phase four
	assign exec_go = clk_en && run && (ph == PH_T4) && !pcl_go;
	assign skip_go = exec_go && is_alu && alu_skip;
	assign stk_full = (stk_cnt == CNT_FULL);
	assign irq_sel = pick_irq(irq_req);
	assign irq_vec = vec_of(irq_sel);
	// Acknowledge only between plain instructions, never on full stack
	assign ack_go = exec_go && (irq_req != '0) && !stk_full && !ir_flow && !skip_go;
	// Fetched word is the successor, so return there
	assign ret_addr = pc - PC_ONE;
	assign push = (exec_go && is_call) || ack_go;
	assign pop = exec_go && (is_ret || is_interrupt_return_op);
	assign stk_top = stk[stack_index - IDX_ONE];
	// Discard the prefetched word: dummy cycle follows
	assign flush = (exec_go && ir_flow) || skip_go || ack_go || pcl_go;

	// Program counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc <= RESET_VEC;
		end else if (clk_en) begin
			if (pcl_go)
				pc <= {pc[PC_W-1:8], pwdata[7:0]};
			else if (ack_go)
				pc <= irq_vec;
			else if (exec_go && (is_jmp || is_call))
				pc <= ir[PC_W-1:0];
			else if (pop)
				pc <= stk_top;
			else if (run && ph == PH_T1)
				pc <= pc + PC_ONE;
		end
	end

	// Fetch port is the counter itself, read in phase one
	assign prog_addr = pc;
	assign prog_rd = run && (ph == PH_T1);

	// Fetch buffer fills while the previous word executes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fetch_buf <= NOP_WORD;
		else if (clk_en && prog_rd)
			fetch_buf <= prog_data;
	end

	// Instruction register; a flushed slot becomes a no-op
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ir <= NOP_WORD;
		else if (flush)
			ir <= NOP_WORD;
		else if (exec_go)
			ir <= fetch_buf;
	end

	// Stack storage needs no reset; entries are written before use
	always_ff @(posedge pclk) begin
		if (clk_en && push)
			stk[stack_index] <= ret_addr;
	end

	// Stack index and occupancy; a full push wraps over the oldest
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_index <= IDX_TOP;
			stk_cnt <= CNT_ZERO;
		end else if (clk_en) begin
			if (push) begin
				stack_index <= stack_index + IDX_ONE;
				if (!stk_full)
					stk_cnt <= stk_cnt + CNT_ONE;
			end else if (pop) begin
				stack_index <= stack_index - IDX_ONE;
				if (stk_cnt != CNT_ZERO)
					stk_cnt <= stk_cnt - CNT_ONE;
			end
		end
	end

	// Accumulator and status take the ALU outcome
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= BYTE_ZERO;
			flags <= '0;
		end else if (exec_go && is_alu) begin
			flags <= alu_flags;
			if (!ir[F_DST])
				acc <= alu_res;
		end
	end

	// Memory write strobe, one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_we <= 1'b0;
			mem_wdata <= BYTE_ZERO;
		end else if (clk_en) begin
			mem_we <= exec_go && is_alu && ir[F_DST];
			if (exec_go && is_alu)
				mem_wdata <= alu_res;
		end
	end

	// Acknowledge and interrupt-return pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack <= '0;
			irq_ret <= 1'b0;
		end else if (clk_en) begin
			irq_ack <= ack_go ? irq_sel : '0;
			irq_ret <= exec_go && is_interrupt_return_op;
		end
	end

	// APB decode
	assign hit_pcl = (paddr == ADDR_PCL);
	assign hit_stat = (paddr == ADDR_STAT);
	assign hit_ctrl = (paddr == ADDR_CTRL);
	assign acc_phase = psel && penable;
	assign pcl_wr = acc_phase && pwrite && hit_pcl;
	// Low-byte write waits for a phase four free of branching, or goes at once when halted
	assign pcl_go = pcl_wr && clk_en && (!run || (ph == PH_T4 && !ir_flow));
	assign pready = clk_en && (!pcl_wr || pcl_go);
	assign pslverr = acc_phase && !(hit_pcl || hit_stat || hit_ctrl);

	// Run control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run <= CTRL_RUN_RST;
		else if (clk_en && acc_phase && pwrite && hit_ctrl)
			run <= pwdata[CTRL_RUN];
	end

	// Read word; stack and upper counter bits are never visible
	always_comb begin
		rd_word = '0;
		if (hit_pcl)
			rd_word[7:0] = pc[7:0];
		else if (hit_stat) begin
			rd_word[3:0] = flags;
			rd_word[STAT_FULL] = stk_full;
			rd_word[STAT_ACC_LO +: 8] = acc;
		end else if (hit_ctrl)
			rd_word[CTRL_RUN] = run;
	end

	// Read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= '0;
		else if (clk_en && psel && !penable)
			prdata <= rd_word;
	end

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_PHASE_LAP: assert property (clk_en && ph == PH_T4 |=> ph == PH_T1)
		else $error("phase four not followed by phase one");
	AST_PC_STEP: assert property (clk_en && run && ph == PH_T1 |=> pc == $past(pc) + PC_ONE)
		else $error("counter did not step in phase one");
	AST_FETCH_T1: assert property (prog_rd |-> ph == PH_T1)
		else $error("fetch outside phase one");
	AST_OSC_PIN: assert property (osc_out_pin |-> ph == PH_T1 && $past(rc_mode))
		else $error("spare pin high outside phase one");
	AST_JUMP: assert property (exec_go && is_jmp |=> pc == $past(ir[PC_W-1:0]) && ir == NOP_WORD)
		else $error("jump target or dummy cycle wrong");
	AST_SKIP: assert property (skip_go |=> ir == NOP_WORD && pc == $past(pc))
		else $error("skip did not discard prefetch");
	AST_PCL: assert property (pcl_go |=> pc == {$past(pc[PC_W-1:8]), $past(pwdata[7:0])})
		else $error("low byte jump left page");
	AST_FULL_ACK: assert property (stk_full |-> !ack_go)
		else $error("acknowledge on full stack");
	AST_CALL_FULL: assert property (exec_go && is_call && stk_full |=> stk_full && pc == $past(ir[PC_W-1:0]))
		else $error("call on full stack did not execute");
	AST_RETURN: assert property (pop |=> pc == $past(stk_top) && ir == NOP_WORD)
		else $error("return did not restore counter");

	COV_CALL: cover property (exec_go && is_call);
	COV_ACK: cover property (ack_go);
	COV_SKIP: cover property (skip_go);
	COV_PCL: cover property (pcl_go);
endmodule // mps_sequencer
`default_nettype wire

/* logic/mps_pkg.sv */
// Shared constants and types for the program sequencer
//
// Contract
// - Four phases make one instruction cycle
// - Phase one advances counter and fetches
// - Fetch overlaps execution, one per cycle
// - Branches take two instruction cycles
// - RC mode drives phase one on pin
// - Counter steps by one unless branching
// - Only low counter byte is software visible
// - Low byte write jumps in page, dummy cycle
// - Met skip discards fetch, resumes at plus two
// - Jump or call loads thirteen address bits
// - Eight-entry hidden return stack of counters
// - Call or acknowledge pushes; returns pop
// - Reset points stack index at top
// - Full stack withholds interrupt acknowledge
// - Call on full stack still executes, overflows
// - Eight-bit ALU works through the accumulator
// - ALU writes destination and updates status
// - ALU covers arithmetic, logic, rotate, skips
// - Fixed vectors: zero, then four-word steps
package mps_pkg;
	localparam int PC_W = 13;
	localparam int STK_DEPTH = 8;
	localparam int IRQ_N = 6;
	localparam int APB_AW = 8;
	localparam logic [12:0] RESET_VEC = 13'h0000;
	localparam logic [12:0] VEC_BASE = 13'h0004;
	localparam logic [12:0] VEC_STEP = 13'h0004;
	localparam logic [12:0] PC_ONE = 13'h0001;
	localparam logic [2:0] IDX_ONE = 3'h1;
	localparam logic [2:0] IDX_TOP = 3'h0;
	localparam logic [3:0] CNT_ONE = 4'h1;
	localparam logic [3:0] CNT_FULL = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	// Register byte addresses
	localparam logic [7:0] ADDR_PCL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	// Register field positions and reset values
	localparam int CTRL_RUN = 0;
	localparam logic CTRL_RUN_RST = 1'b1;
	localparam int STAT_FULL = 4;
	localparam int STAT_ACC_LO = 8;
	// Instruction word fields
	localparam int F_CLS_HI = 15;
	localparam int F_CLS_LO = 14;
	localparam int F_CALL = 13;
	localparam int F_FN_HI = 13;
	localparam int F_FN_LO = 9;
	localparam int F_DST = 8;
	localparam int F_MSUB_HI = 13;
	localparam int F_MSUB_LO = 12;
	localparam logic [1:0] CLS_MISC = 2'h1;
	localparam logic [1:0] CLS_ALU = 2'h2;
	localparam logic [1:0] CLS_JMP = 2'h3;
	localparam logic [1:0] MISC_RET = 2'h0;
	localparam logic [1:0] MISC_INTERRUPT_RETURN_OP = 2'h1;
	localparam logic [15:0] NOP_WORD = 16'h0000;
	// Decimal adjust constants
	localparam logic [3:0] DAA_NIB_MAX = 4'h9;
	localparam logic [7:0] DAA_LO = 8'h06;
	localparam logic [7:0] DAA_HI = 8'h60;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONE = 8'h01;
	localparam logic [7:0] BYTE_ALL = 8'hff;
	// Instruction cycle phases
	typedef enum logic [3:0] {
		PH_T1 = 4'h1,
		PH_T2 = 4'h2,
		PH_T3 = 4'h4,
		PH_T4 = 4'h8
	} mps_phase_t;
	// ALU functions
	typedef enum logic [4:0] {
		ALU_ADD = 5'h00, ALU_ADC = 5'h01, ALU_SUB = 5'h02, ALU_SBC = 5'h03,
		ALU_DAA = 5'h04, ALU_AND = 5'h05, ALU_OR = 5'h06, ALU_XOR = 5'h07,
		ALU_CPL = 5'h08, ALU_RR = 5'h09, ALU_RRC = 5'h0a, ALU_RL = 5'h0b,
		ALU_RLC = 5'h0c, ALU_INC = 5'h0d, ALU_DEC = 5'h0e, ALU_MOV = 5'h0f,
		ALU_SZ = 5'h10, ALU_SNZ = 5'h11, ALU_SIZ = 5'h12, ALU_SDZ = 5'h13
	} mps_alu_op_t;
	// Status flags
	typedef struct packed {
		logic c;
		logic ac;
		logic z;
		logic ov;
	} mps_flags_t;
endpackage

/* logic/mps_alu.sv */
// Eight-bit ALU with status flags and skip decision
`timescale 1ns/1ps
`default_nettype none
module mps_alu (
	input wire mps_pkg::mps_alu_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire mps_pkg::mps_flags_t flags_in,
	output logic [7:0] result,
	output mps_pkg::mps_flags_t flags_out,
	output logic skip
);
	import mps_pkg::*;

	// Adder returning {ov, ac, c, sum}
	function automatic logic [10:0] add_f(input logic [7:0] x, input logic [7:0] y,
		input logic ci);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
		h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
		add_f = {(x[7] == y[7]) && (s[7] != x[7]), h[4], s[8], s[7:0]};
	endfunction

	logic [10:0] s;

	// Operation select; borrow shows as carry low
	always_comb begin
		s = add_f(a, b, 1'b0);
		result = b;
		flags_out = flags_in;
		skip = 1'b0;
		case (op)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
				case (op)
					ALU_ADC: s = add_f(a, b, flags_in.c);
					ALU_SUB: s = add_f(a, ~b, 1'b1);
					ALU_SBC: s = add_f(a, ~b, flags_in.c);
					default: s = add_f(a, b, 1'b0);
				endcase
				result = s[7:0];
				{flags_out.ov, flags_out.ac, flags_out.c} = s[10:8];
			end
			ALU_DAA: begin
				s = add_f(a, (a[3:0] > DAA_NIB_MAX || flags_in.ac) ? DAA_LO : BYTE_ZERO, 1'b0);
				result = s[7:0];
				if (s[7:4] > DAA_NIB_MAX || flags_in.c || s[8]) begin
					result = s[7:0] + DAA_HI;
					flags_out.c = 1'b1;
				end
			end
			ALU_AND: result = a & b;
			ALU_OR: result = a | b;
			ALU_XOR: result = a ^ b;
			ALU_CPL: result = ~b;
			ALU_RR: result = {b[0], b[7:1]};
			ALU_RL: result = {b[6:0], b[7]};
			ALU_RRC: {result, flags_out.c} = {flags_in.c, b};
			ALU_RLC: {flags_out.c, result} = {b, flags_in.c};
			ALU_INC: result = b + BYTE_ONE;
			ALU_DEC: result = b + BYTE_ALL;
			ALU_SZ: skip = (b == BYTE_ZERO);
			ALU_SNZ: skip = (b != BYTE_ZERO);
			ALU_SIZ: begin
				result = b + BYTE_ONE;
				skip = (result == BYTE_ZERO);
			end
			ALU_SDZ: begin
				result = b + BYTE_ALL;
				skip = (result == BYTE_ZERO);
			end
			default: result = b;
		endcase
		// Zero flag follows arithmetic, logic, increment and decrement
		if (op <= ALU_CPL || op == ALU_INC || op == ALU_DEC)
			flags_out.z = (result == BYTE_ZERO);
	end
endmodule // mps_alu
`default_nettype wire

/* dv/mps_prog_mem.sv */
// Program memory model that answers instruction fetches
`timescale 1ns/1ps
`default_nettype none
module mps_prog_mem (
	input wire logic pclk,
	input wire logic [12:0] prog_addr,
	input wire logic prog_rd,
	output wire logic [15:0] prog_data
);
	logic [15:0] mem [0:8191]; // Words, empty slots read as no-op
	logic [15:0] last; // Last word handed out
	// Start from an all no-op image
	initial begin
		foreach (mem[i]) begin
			mem[i] = 16'h0000;
		end
		last = 16'h0000;
	end
	// Outside a fetch the bus shows junk so stale data cannot pass
	assign prog_data = (prog_rd === 1'b1) ? mem[prog_addr] : ~last;
	// Remember what was handed out
	always @(posedge pclk) begin
		if (prog_rd === 1'b1) begin
			last <= mem[prog_addr];
		end
	end
endmodule // mps_prog_mem
`default_nettype wire

/* dv/mps_sequencer_bench.sv */
// Self-checking bench for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module mps_sequencer_bench;
	import mps_pkg::*;
	logic pclk, presetn, clk_en, psel, penable, pwrite, rc_mode_pin;
	logic [7:0] paddr, mem_addr, mem_rdata, mem_wdata;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, prog_rd, mem_we, irq_ret, osc_out_pin, er;
	logic [12:0] prog_addr, lastf;
	logic [15:0] prog_data;
	logic [5:0] irq_req, irq_ack;
	int error_cnt, n_tests, cyc, ts, nack, nret;
	logic [12:0] fq[$]; // Fetch addresses in order
	int tq[$]; // Cycle of each fetch
	logic [7:0] wq[$]; // Data memory writes
	assign mem_rdata = ~mem_addr; // Operand derived from its address
	mps_sequencer mps_sequencer_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
		.prog_rd(prog_rd), .prog_data(prog_data), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.irq_req(irq_req), .irq_ack(irq_ack), .irq_ret(irq_ret),
		.rc_mode_pin(rc_mode_pin), .osc_out_pin(osc_out_pin));
	mps_prog_mem mps_prog_mem_i (.pclk(pclk), .prog_addr(prog_addr), .prog_rd(prog_rd),
		.prog_data(prog_data));
	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// Monitor plus hang guard
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (prog_rd === 1'b1 && presetn === 1'b1) begin
			fq.push_back(prog_addr);
			tq.push_back(cyc);
			lastf <= prog_addr;
		end
		if (mem_we === 1'b1) wq.push_back(mem_wdata);
		if (irq_ack !== 6'h00) nack++;
		if (irq_ret === 1'b1) nret++;
		if (cyc == 20000) begin
			error_cnt++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Next fetch address, bounded wait
	task automatic ef(input logic [12:0] e);
		int k;
		k = 0;
		while (fq.size() == 0 && k < 200) begin
			@(posedge pclk);
			k++;
		end
		if (fq.size() == 0) begin
			error_cnt++;
			final_report();
		end else begin
			ts = tq.pop_front();
			chk(fq.pop_front(), e);
		end
	endtask
	// Skip ahead to a fetch of one address
	task automatic wait_at(input logic [12:0] e);
		int k;
		k = 0;
		while (fq.size() == 0 || fq[0] !== e) begin
			if (fq.size() > 0) begin
				void'(fq.pop_front());
				void'(tq.pop_front());
			end
			@(posedge pclk);
			k++;
			if (k > 2000) chk(13'h1fff, e);
			if (k > 2000) final_report();
		end
		ef(e);
	endtask
	// One APB transfer; waits for pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 100);
		if (k >= 100) begin
			error_cnt++;
			final_report();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rst();
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		fq.delete();
		tq.delete();
		wq.delete();
	endtask
	function automatic logic [15:0] alu(input logic [4:0] op, input logic d, input logic [7:0] ad);
		return {CLS_ALU, op, d, ad};
	endfunction
	task automatic t_pipe();
		int t0;
		int nh;
		rst();
		nh = 0;
		ef(13'h0000);
		t0 = ts;
		ef(13'h0001);
		chk(32'(ts - t0), 32'h0000_0004);
		repeat (8) begin
			@(negedge pclk);
			chk(osc_out_pin, prog_rd);
			nh += int'(osc_out_pin);
		end
		chk(nh, 2);
		rc_mode_pin <= 1'b0;
		repeat (4) @(negedge pclk);
		repeat (8) begin
			@(negedge pclk);
			chk(osc_out_pin, 1'b0);
		end
		rc_mode_pin <= 1'b1;
	endtask
	task automatic t_pcl();
		logic [31:0] s;
		mps_prog_mem_i.mem[0] = 16'hc123;
		rst();
		ef(13'h0000);
		ef(13'h0001);
		ef(13'h0123);
		apb(1'b1, ADDR_PCL, 32'h0000_0050);
		fq.delete();
		tq.delete();
		ef(13'h0150);
		apb(1'b0, ADDR_CTRL, 32'h0000_0000);
		chk(rd[CTRL_RUN], CTRL_RUN_RST);
		apb(1'b1, ADDR_CTRL, 32'h0000_0000);
		repeat (4) @(posedge pclk);
		fq.delete();
		repeat (12) @(posedge pclk);
		chk(fq.size(), 0);
		apb(1'b1, ADDR_PCL, 32'h0000_0077);
		apb(1'b0, ADDR_PCL, 32'h0000_0000);
		chk(rd[7:0], 8'h77);
		apb(1'b0, ADDR_STAT, 32'h0000_0000);
		s = rd;
		apb(1'b1, ADDR_STAT, 32'hffff_ffff);
		apb(1'b0, ADDR_STAT, 32'h0000_0000);
		chk(rd, s);
		apb(1'b0, 8'h0c, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		chk(rd, 32'h0000_0000);
		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		fq.delete();
		tq.delete();
		ef(13'h0177);
	endtask
	task automatic t_call();
		mps_prog_mem_i.mem[0] = 16'he300;
		mps_prog_mem_i.mem[13'h0300] = 16'h4000;
		rst();
		ef(13'h0000);
		ef(13'h0001);
		ef(13'h0300);
		ef(13'h0301);
		ef(13'h0001);
		ef(13'h0002);
	endtask
	task automatic t_alu();
		mps_prog_mem_i.mem[0] = 16'hc400;
		mps_prog_mem_i.mem[13'h0400] = alu(ALU_MOV, 1'b0, 8'h65);
		mps_prog_mem_i.mem[13'h0401] = alu(ALU_ADD, 1'b0, 8'h99);
		mps_prog_mem_i.mem[13'h0402] = alu(ALU_DEC, 1'b1, 8'h99);
		mps_prog_mem_i.mem[13'h0403] = alu(ALU_SZ, 1'b0, 8'hff);
		mps_prog_mem_i.mem[13'h0404] = 16'hc7ff;
		mps_prog_mem_i.mem[13'h0405] = alu(ALU_SNZ, 1'b0, 8'hff);
		mps_prog_mem_i.mem[13'h0406] = 16'hc500;
		for (int i = 0; i < 20; i++) begin
			mps_prog_mem_i.mem[13'h0500 + 2 * i] = alu(5'(i), 1'b1, 8'h99);
		end
		rst();
		ef(13'h0000);
		ef(13'h0001);
		for (int a = 'h400; a < 'h408; a++) begin
			ef(13'(a));
		end
		ef(13'h0500);
		apb(1'b0, ADDR_STAT, 32'h0000_0000);
		chk(rd[15:0], 16'h000c);
		chk(wq[0], 8'h65);
		wait_at(13'h0528);
		chk(wq.size(), 21);
		chk(wq[9], 8'h99);
		chk(wq[14], 8'h67);
	endtask
	task automatic t_irq();
		logic [12:0] r;
		int k;
		mps_prog_mem_i.mem[0] = 16'hc600;
		for (int i = 0; i < 6; i++) begin
			mps_prog_mem_i.mem[4 + 4 * i] = 16'h5000;
		end
		rst();
		for (int i = 0; i < 6; i++) begin
			irq_req <= 6'h01 << i;
			k = 0;
			do begin
				@(negedge pclk);
				k++;
			end while (irq_ack === 6'h00 && k < 100);
			chk(irq_ack, 6'h01 << i);
			r = lastf;
			fq.delete();
			tq.delete();
			@(posedge pclk);
			irq_req <= 6'h00;
			ef(13'(4 + 4 * i));
			ef(13'(5 + 4 * i));
			ef(r);
			chk(nret, i + 1);
		end
	endtask
	task automatic t_full();
		int n0;
		int k;
		mps_prog_mem_i.mem[0] = 16'hc700;
		for (int j = 0; j < 8; j++) begin
			mps_prog_mem_i.mem[13'h0700 + 16 * j] = 16'(32'he710 + 16 * j);
		end
		mps_prog_mem_i.mem[13'h0780] = 16'he7c0;
		mps_prog_mem_i.mem[13'h07c8] = 16'h4000;
		rst();
		wait_at(13'h07c0);
		apb(1'b0, ADDR_STAT, 32'h0000_0000);
		chk(rd[STAT_FULL], 1'b1);
		irq_req <= 6'h01;
		n0 = nack;
		wait_at(13'h07c8);
		chk(nack - n0, 0);
		k = 0;
		while (nack == n0 && k < 40) begin
			@(posedge pclk);
			k++;
		end
		chk(nack - n0, 1);
		irq_req <= 6'h00;
	endtask
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		irq_req = 6'h00;
		rc_mode_pin = 1'b1;
		error_cnt = 0;
		n_tests = 0;
		cyc = 0;
		nack = 0;
		nret = 0;
		t_pipe();
		t_pcl();
		t_call();
		t_alu();
		t_irq();
		t_full();
		final_report();
	end
endmodule // mps_sequencer_bench
`default_nettype wire
